// ===== inc/dcc_defs.vh
/*
 Register offsets, field positions, reset values and encodings of the
 DMA channel control and configuration block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// ==========================================================================
// Register byte offsets
`define DCC_OFS_SRC_ADDR 12'h000
`define DCC_OFS_DST_ADDR 12'h008
`define DCC_OFS_CTL_LO 12'h018
`define DCC_OFS_CTL_HI 12'h01C
`define DCC_OFS_CFG_LO 12'h040
`define DCC_OFS_CFG_HI 12'h044
`define DCC_OFS_CH_EN 12'h060
`define DCC_OFS_SW_REQ 12'h064

// ==========================================================================
// Reset values
`define DCC_RST_CTL_LO 32'h0030_4801
`define DCC_RST_CTL_HI 32'h0000_0002
`define DCC_RST_CFG_LO 32'h0000_0C00
`define DCC_RST_CFG_HI 32'h0000_0004
`define DCC_RST_BLK_TS 12'h002

// ==========================================================================
// Writable bits of the configuration words
`define DCC_WMASK_CFG_LO 32'hC00C_0DE0
`define DCC_WMASK_CFG_HI 32'h0000_7F9F

// ==========================================================================
// Control low fields
`define DCC_INT_EN 0
`define DCC_DXS_LO 1
`define DCC_SXS_LO 4
`define DCC_DSTEP_LO 7
`define DCC_SSTEP_LO 9
`define DCC_DBURST_LO 11
`define DCC_SBURST_LO 14
`define DCC_TTFC_LO 20

// ==========================================================================
// Control high fields
`define DCC_DONE_BIT 12

// ==========================================================================
// Configuration low fields
`define DCC_DRESTORE_BIT 31
`define DCC_SRESTORE_BIT 30
`define DCC_SPOL_BIT 19
`define DCC_DPOL_BIT 18
`define DCC_SHS_BIT 11
`define DCC_DHS_BIT 10
`define DCC_EMPTY_BIT 9
`define DCC_PAUSE_BIT 8
`define DCC_RANK_LO 5

// ==========================================================================
// Configuration high fields
`define DCC_DPORT_LO 11
`define DCC_SPORT_LO 7
`define DCC_PROT_LO 2
`define DCC_FMODE_BIT 1
`define DCC_HOLD_BIT 0

// ==========================================================================
// Address step codes
`define DCC_STEP_INC 2'h0
`define DCC_STEP_DEC 2'h1

`endif

// ===== logic/dcc_channel.v
/*
 One DMA channel: control and configuration registers, request handshake
 selection, burst and block sequencing, address stepping and FIFO fill
 accounting.
 Assumes a single 50 MHz clock, a simple strobe register port and a system
 bus that accepts one source and one destination transfer per cycle.
*/
// The strobed register port was left to the implementer.
// Functional notes
// - destination burst code selects 1..32 items
// - source address increments, decrements or holds
// - destination address increments, decrements or holds
// - width codes give 8, 16, 32 bits
// - interrupt enable gates all five events
// - done bit 12 set at block end
// - block size read returns progress while running
// - single transactions counted in source width
// - restore bits reload addresses, new block
// - polarity bits select request active level
// - source handshake choice hardware or software
// - destination handshake choice hardware or software
// - bit 9 reads one when FIFO empty
// - pause stops source transfers until cleared
// - rank seven highest, zero lowest
// - port fields pick hardware handshake line
// - protection bits drive prot[3:1], prot[0] high
// - FIFO mode sets service thresholds
// - hold mode gates source on destination request
// - source burst code selects 1..32 items
`timescale 1ns/1ps
`include "dcc_defs.vh"

module dcc_channel #(
   parameter NUM_HS = 16,
   parameter FIFO_BYTES = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Hardware handshake request lines
   input wire [NUM_HS-1:0] src_hw_req,
   input wire [NUM_HS-1:0] dst_hw_req,
   // System bus transfer requests
   output reg src_bus_go,
   output reg [31:0] src_bus_addr,
   output reg [1:0] src_bus_size,
   output reg dst_bus_go,
   output reg [31:0] dst_bus_addr,
   output reg [1:0] dst_bus_size,
   output reg [3:0] bus_prot,
   input wire bus_error,
   // Channel status
   output reg [2:0] channel_rank_out,
   output reg ch_active,
   output reg [4:0] int_events
);

   // ======================================================================
   // Decoders

   function [5:0] burst_items;
      input [2:0] code;
      begin
         case (code)
            3'd0: burst_items = 6'd1;
            3'd1: burst_items = 6'd4;
            3'd2: burst_items = 6'd8;
            3'd3: burst_items = 6'd16;
            3'd4: burst_items = 6'd32;
            default: burst_items = 6'd1;
         endcase
      end
   endfunction

   function [2:0] width_bytes;
      input [2:0] code;
      begin
         case (code)
            3'd0: width_bytes = 3'd1;
            3'd1: width_bytes = 3'd2;
            3'd2: width_bytes = 3'd4;
            default: width_bytes = 3'd1;
         endcase
      end
   endfunction

   function [31:0] step_addr;
      input [31:0] a;
      input [1:0] code;
      input [2:0] nb;
      begin
         if (code == `DCC_STEP_INC)
            step_addr = a + {29'h0000_000, nb};
         else if (code == `DCC_STEP_DEC)
            step_addr = a - {29'h0000_000, nb};
         else
            step_addr = a;
      end
   endfunction

   // ======================================================================
   // State

   reg [31:0] ctl_lo_reg, cfg_lo_reg, cfg_hi_reg;
   reg [11:0] block_transaction_count_reg, src_cnt_reg;
   reg done_reg;
   reg [31:0] src_addr_reg, dst_addr_reg, src_init_reg, dst_init_reg;
   reg run_reg, sw_src_reg, sw_dst_reg, dst_seen_reg;
   reg [5:0] src_left_reg, dst_left_reg;
   reg [7:0] fifo_reg;
   reg [NUM_HS-1:0] s1_src, s2_src, s3_src, f_src;
   reg [NUM_HS-1:0] s1_dst, s2_dst, s3_dst, f_dst;

   // ======================================================================
   // Field views

   wire [2:0] dxs = ctl_lo_reg[`DCC_DXS_LO+2:`DCC_DXS_LO];
   wire [2:0] sxs = ctl_lo_reg[`DCC_SXS_LO+2:`DCC_SXS_LO];
   wire [1:0] dstep = ctl_lo_reg[`DCC_DSTEP_LO+1:`DCC_DSTEP_LO];
   wire [1:0] sstep = ctl_lo_reg[`DCC_SSTEP_LO+1:`DCC_SSTEP_LO];
   wire [2:0] ttfc = ctl_lo_reg[`DCC_TTFC_LO+2:`DCC_TTFC_LO];
   wire src_mem = ~ttfc[1];
   wire dst_mem = ~ttfc[0];
   wire [3:0] sport = cfg_hi_reg[`DCC_SPORT_LO+3:`DCC_SPORT_LO];
   wire [3:0] dport = cfg_hi_reg[`DCC_DPORT_LO+3:`DCC_DPORT_LO];
   wire pause = cfg_lo_reg[`DCC_PAUSE_BIT];
   wire fmode = cfg_hi_reg[`DCC_FMODE_BIT];
   wire hold = cfg_hi_reg[`DCC_HOLD_BIT];
   wire [2:0] sbytes = width_bytes(sxs);
   wire [2:0] dbytes = width_bytes(dxs);
   wire [5:0] sburst = burst_items(ctl_lo_reg[`DCC_SBURST_LO+2:`DCC_SBURST_LO]);
   wire [5:0] dburst = burst_items(ctl_lo_reg[`DCC_DBURST_LO+2:`DCC_DBURST_LO]);
   localparam [31:0] HALF_W = FIFO_BYTES / 2;
   localparam [31:0] DEPTH_W = FIFO_BYTES;
   wire [7:0] half = HALF_W[7:0];
   wire [7:0] depth = DEPTH_W[7:0];

   // ======================================================================
   // Request selection

   wire hw_src = (f_src[sport] ^ cfg_lo_reg[`DCC_SPOL_BIT]);
   wire hw_dst = (f_dst[dport] ^ cfg_lo_reg[`DCC_DPOL_BIT]);
   wire src_req = src_mem | (cfg_lo_reg[`DCC_SHS_BIT] ? sw_src_reg : hw_src);
   wire dst_req = dst_mem | (cfg_lo_reg[`DCC_DHS_BIT] ? sw_dst_reg : hw_dst);

   wire [11:0] src_rem = block_transaction_count_reg - src_cnt_reg;
   wire src_done = (src_cnt_reg == block_transaction_count_reg) && (src_left_reg == 6'd0);
   wire src_end = (src_rem <= {6'h00, sburst});
   wire src_thr = ~fmode | (fifo_reg < half) | src_end;
   wire dst_thr = ~fmode | (fifo_reg >= half) | src_done;
   wire src_gate = ~hold | dst_mem | dst_seen_reg;

   wire src_load = run_reg & ~pause & (src_left_reg == 6'd0) & (src_rem != 12'h000)
                   & src_req & src_thr & src_gate;
   wire src_xfer = run_reg & ~pause & (src_left_reg != 6'd0)
                   & ({5'h00, sbytes} <= depth - fifo_reg);
   wire dst_load = run_reg & (dst_left_reg == 6'd0) & dst_req & dst_thr & (fifo_reg != 8'h00);
   wire dst_xfer = run_reg & (dst_left_reg != 6'd0)
                   & ((fifo_reg >= {5'h00, dbytes}) | (src_done & fifo_reg != 8'h00));
   wire dst_flush = run_reg & (dst_left_reg != 6'd0) & src_done & (fifo_reg == 8'h00);
   wire block_end = run_reg & src_done & (fifo_reg == 8'h00) & ~src_xfer;
   wire restore = cfg_lo_reg[`DCC_DRESTORE_BIT] | cfg_lo_reg[`DCC_SRESTORE_BIT];

   wire wr_ctl_hi = reg_wr && reg_addr == `DCC_OFS_CTL_HI;
   wire wr_en = reg_wr && reg_addr == `DCC_OFS_CH_EN;
   wire wr_sw = reg_wr && reg_addr == `DCC_OFS_SW_REQ;

   // ======================================================================
   // Request line synchronisers

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_src <= {NUM_HS{1'b0}};
         s2_src <= {NUM_HS{1'b0}};
         s3_src <= {NUM_HS{1'b0}};
         f_src <= {NUM_HS{1'b0}};
         s1_dst <= {NUM_HS{1'b0}};
         s2_dst <= {NUM_HS{1'b0}};
         s3_dst <= {NUM_HS{1'b0}};
         f_dst <= {NUM_HS{1'b0}};
      end else begin
         s1_src <= src_hw_req;
         s2_src <= s1_src;
         s3_src <= s2_src;
         f_src <= (s3_src & ~(s2_src ^ s3_src)) | (f_src & (s2_src ^ s3_src));
         s1_dst <= dst_hw_req;
         s2_dst <= s1_dst;
         s3_dst <= s2_dst;
         f_dst <= (s3_dst & ~(s2_dst ^ s3_dst)) | (f_dst & (s2_dst ^ s3_dst));
      end
   end

   // ======================================================================
   // Registers and transfer engine

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_lo_reg <= `DCC_RST_CTL_LO;
         cfg_lo_reg <= `DCC_RST_CFG_LO;
         cfg_hi_reg <= `DCC_RST_CFG_HI;
         block_transaction_count_reg <= `DCC_RST_BLK_TS;
         done_reg <= 1'b0;
         src_addr_reg <= 32'h0000_0000;
         dst_addr_reg <= 32'h0000_0000;
         src_init_reg <= 32'h0000_0000;
         dst_init_reg <= 32'h0000_0000;
         run_reg <= 1'b0;
         sw_src_reg <= 1'b0;
         sw_dst_reg <= 1'b0;
         dst_seen_reg <= 1'b0;
         src_cnt_reg <= 12'h000;
         src_left_reg <= 6'd0;
         dst_left_reg <= 6'd0;
         fifo_reg <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == `DCC_OFS_CTL_LO)
            ctl_lo_reg <= reg_wdata;
         if (reg_wr && reg_addr == `DCC_OFS_CFG_LO)
            cfg_lo_reg <= reg_wdata & `DCC_WMASK_CFG_LO;
         if (reg_wr && reg_addr == `DCC_OFS_CFG_HI)
            cfg_hi_reg <= reg_wdata & `DCC_WMASK_CFG_HI;
         if (wr_ctl_hi)
            block_transaction_count_reg <= reg_wdata[11:0];
         // Hardware set wins over a software write of zero.
         if (block_end)
            done_reg <= 1'b1;
         else if (wr_ctl_hi)
            done_reg <= reg_wdata[`DCC_DONE_BIT];
         if (wr_sw) begin
            sw_src_reg <= sw_src_reg | reg_wdata[0];
            sw_dst_reg <= sw_dst_reg | reg_wdata[1];
         end
         if (src_load)
            sw_src_reg <= wr_sw & reg_wdata[0];
         if (dst_load)
            sw_dst_reg <= wr_sw & reg_wdata[1];
         if (dst_req & run_reg & ~dst_mem)
            dst_seen_reg <= 1'b1;
         else if (block_end)
            dst_seen_reg <= 1'b0;

         if (src_load)
            src_left_reg <= (src_rem < {6'h00, sburst}) ? src_rem[5:0] : sburst;
         else if (src_xfer)
            src_left_reg <= src_left_reg - 6'd1;
         if (dst_load)
            dst_left_reg <= dburst;
         else if (dst_flush)
            dst_left_reg <= 6'd0;
         else if (dst_xfer)
            dst_left_reg <= dst_left_reg - 6'd1;

         if (src_xfer)
            src_cnt_reg <= src_cnt_reg + 12'h001;
         if (src_xfer & ~dst_xfer)
            fifo_reg <= fifo_reg + {5'h00, sbytes};
         else if (dst_xfer & ~src_xfer)
            fifo_reg <= (fifo_reg > {5'h00, dbytes}) ? fifo_reg - {5'h00, dbytes} : 8'h00;
         else if (dst_xfer & src_xfer)
            fifo_reg <= fifo_reg + {5'h00, sbytes} - {5'h00, dbytes};

         if (reg_wr && reg_addr == `DCC_OFS_SRC_ADDR) begin
            src_addr_reg <= reg_wdata;
            src_init_reg <= reg_wdata;
         end else if (src_xfer)
            src_addr_reg <= step_addr(src_addr_reg, sstep, sbytes);
         else if (block_end & cfg_lo_reg[`DCC_SRESTORE_BIT])
            src_addr_reg <= src_init_reg;
         if (reg_wr && reg_addr == `DCC_OFS_DST_ADDR) begin
            dst_addr_reg <= reg_wdata;
            dst_init_reg <= reg_wdata;
         end else if (dst_xfer)
            dst_addr_reg <= step_addr(dst_addr_reg, dstep, dbytes);
         else if (block_end & cfg_lo_reg[`DCC_DRESTORE_BIT])
            dst_addr_reg <= dst_init_reg;

         if (bus_error) begin
            run_reg <= 1'b0;
         end else if (wr_en) begin
            run_reg <= reg_wdata[0];
            src_cnt_reg <= 12'h000;
            src_left_reg <= 6'd0;
            dst_left_reg <= 6'd0;
            fifo_reg <= 8'h00;
         end else if (block_end) begin
            src_cnt_reg <= 12'h000;
            run_reg <= restore;
         end
      end
   end

   // ======================================================================
   // Bus outputs and events

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         src_bus_go <= 1'b0;
         src_bus_addr <= 32'h0000_0000;
         src_bus_size <= 2'd0;
         dst_bus_go <= 1'b0;
         dst_bus_addr <= 32'h0000_0000;
         dst_bus_size <= 2'd0;
         bus_prot <= 4'h3;
         channel_rank_out <= 3'd0;
         ch_active <= 1'b0;
         int_events <= 5'h00;
      end else begin
         src_bus_go <= src_xfer;
         src_bus_addr <= src_addr_reg;
         src_bus_size <= sxs[1:0];
         dst_bus_go <= dst_xfer;
         dst_bus_addr <= dst_addr_reg;
         dst_bus_size <= dxs[1:0];
         bus_prot <= {cfg_hi_reg[`DCC_PROT_LO+2:`DCC_PROT_LO], 1'b1};
         channel_rank_out <= cfg_lo_reg[`DCC_RANK_LO+2:`DCC_RANK_LO];
         ch_active <= run_reg;
         // Order: transfer, block, source txn, destination txn, error.
         int_events <= {5{ctl_lo_reg[`DCC_INT_EN]}} & {
            block_end & ~restore,
            block_end,
            src_xfer & (src_left_reg == 6'd1) & ~src_mem,
            dst_xfer & (dst_left_reg == 6'd1) & ~dst_mem,
            bus_error & run_reg};
      end
   end

   // ======================================================================
   // Register read port

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `DCC_OFS_SRC_ADDR: reg_rdata <= src_addr_reg;
            `DCC_OFS_DST_ADDR: reg_rdata <= dst_addr_reg;
            `DCC_OFS_CTL_LO: reg_rdata <= ctl_lo_reg;
            `DCC_OFS_CTL_HI: reg_rdata <= {19'h0_0000, done_reg,
                                           run_reg ? src_cnt_reg : block_transaction_count_reg};
            `DCC_OFS_CFG_LO: reg_rdata <= cfg_lo_reg
                                          | {22'h00_0000, fifo_reg == 8'h00, 9'h000};
            `DCC_OFS_CFG_HI: reg_rdata <= cfg_hi_reg;
            `DCC_OFS_CH_EN: reg_rdata <= {31'h0000_0000, run_reg};
            `DCC_OFS_SW_REQ: reg_rdata <= {30'h0000_0000, sw_dst_reg, sw_src_reg};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// ===== sim/dcc_channel_props.sv
/*
 Concurrent checks on the ports of one DMA channel.
 Assumes one clock, active-high async reset and shadows built from register writes.
*/
`timescale 1ns/1ps
module dcc_channel_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Register port
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   // Bus side and status
   input wire src_bus_go,
   input wire [31:0] src_bus_addr,
   input wire [1:0] src_bus_size,
   input wire dst_bus_go,
   input wire [31:0] dst_bus_addr,
   input wire [1:0] dst_bus_size,
   input wire [3:0] bus_prot,
   input wire bus_error,
   input wire [2:0] channel_rank_out,
   input wire ch_active,
   input wire [4:0] int_events
);
   // ======================================================================
   // Shadows of the written fields
   logic int_reg, pause_reg, sseen_reg, dseen_reg;
   logic [2:0] prot_reg, rank_reg;
   logic [1:0] sw_reg, dw_reg, ss_reg, ds_reg;
   logic [31:0] slast_reg, dlast_reg;
   wire restart = reg_wr && (reg_addr == 12'h060 || reg_addr[11:4] == 8'h00);
   wire [31:0] sexp = ss_reg == 2'h0 ? slast_reg + (32'h1 << sw_reg) : ss_reg == 2'h1 ? slast_reg - (32'h1 << sw_reg) : slast_reg;
   wire [31:0] dexp = ds_reg == 2'h0 ? dlast_reg + (32'h1 << dw_reg) : ds_reg == 2'h1 ? dlast_reg - (32'h1 << dw_reg) : dlast_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_reg <= 1'b1;
         pause_reg <= 1'b0;
         {sw_reg, dw_reg, ss_reg, ds_reg} <= 8'h00;
         prot_reg <= 3'h1;
         rank_reg <= 3'h0;
         sseen_reg <= 1'b0;
         dseen_reg <= 1'b0;
         slast_reg <= 32'h0000_0000;
         dlast_reg <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == 12'h018) begin
            int_reg <= reg_wdata[0];
            dw_reg <= reg_wdata[2:1];
            sw_reg <= reg_wdata[5:4];
            ds_reg <= reg_wdata[8:7];
            ss_reg <= reg_wdata[10:9];
         end
         if (reg_wr && reg_addr == 12'h040) begin
            pause_reg <= reg_wdata[8];
            rank_reg <= reg_wdata[7:5];
         end
         if (reg_wr && reg_addr == 12'h044) begin
            prot_reg <= reg_wdata[4:2];
         end
         sseen_reg <= !restart && (sseen_reg || src_bus_go);
         dseen_reg <= !restart && (dseen_reg || dst_bus_go);
         if (src_bus_go) begin
            slast_reg <= src_bus_addr;
         end
         if (dst_bus_go) begin
            dlast_reg <= dst_bus_addr;
         end
      end
   end
   // ======================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_PROT_TIE: assert property (bus_prot[0]) else $error("prot bit 0 low");
   AST_PROT_MAP: assert property ($stable(prot_reg) |-> bus_prot[3:1] == prot_reg) else $error("prot field lost");
   AST_RANK_COPY: assert property ($stable(rank_reg) |-> channel_rank_out == rank_reg) else $error("rank wrong");
   AST_SRC_SIZE: assert property (src_bus_go |-> src_bus_size == sw_reg) else $error("source size wrong");
   AST_DST_SIZE: assert property (dst_bus_go |-> dst_bus_size == dw_reg) else $error("dest size wrong");
   AST_SRC_STEP: assert property (src_bus_go && sseen_reg |-> src_bus_addr == sexp) else $error("source step");
   AST_DST_STEP: assert property (dst_bus_go && dseen_reg |-> dst_bus_addr == dexp) else $error("dest step");
   AST_PAUSE_HALT: assert property (pause_reg [*5] |-> !src_bus_go) else $error("source ran while paused");
   AST_INT_MASKED: assert property (!int_reg && !$past(int_reg) |-> int_events == 5'h00) else $error("event leak");
   AST_ERR_EVENT: assert property (bus_error && ch_active && int_reg |=> int_events[0]) else $error("no err event");
   cover property (src_bus_go ##1 src_bus_go);
   cover property (int_events[3]);
   cover property (pause_reg && ch_active);
   cover property (bus_error && ch_active);
endmodule
bind dcc_channel dcc_channel_props chk_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .src_bus_go, .src_bus_addr,
   .src_bus_size, .dst_bus_go, .dst_bus_addr, .dst_bus_size, .bus_prot, .bus_error, .channel_rank_out, .ch_active,
   .int_events);

// ===== sim/dcc_periph_model.sv
/*
 Peripheral request lines and bus error source facing the channel.
 Assumes the bench sets polarity, line number and error pulses at clock edges.
*/
`timescale 1ns/1ps
module dcc_periph_model (
   // Bench controls
   input wire src_low,
   input wire src_want,
   input wire [3:0] src_port,
   input wire err_want,
   // Lines toward the channel
   output wire [15:0] src_hw_req,
   output wire [15:0] dst_hw_req,
   output wire bus_error
);
   // Only the src_port line is driven active, so each handshake line has a single user.
   assign src_hw_req = {16{src_low}} ^ (src_want ? 16'h0001 << src_port : 16'h0000);
   assign dst_hw_req = 16'h0000;
   assign bus_error = err_want;
endmodule

// ===== sim/tb_dcc_channel.sv
/*
 Self-checking bench for one DMA channel.
 Assumes the strobe register port and the peripheral model beside it.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module tb_dcc_channel;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, src_low = 0, src_want = 0, err_want = 0;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, src_bus_addr, dst_bus_addr, sa, da;
   logic [15:0] src_hw_req, dst_hw_req;
   logic [3:0] src_port = 0, bus_prot;
   logic [1:0] src_bus_size, dst_bus_size;
   logic [2:0] channel_rank_out;
   logic [4:0] int_events, ev = 0;
   logic src_bus_go, dst_bus_go, bus_error, ch_active;
   int ns = 0, nd = 0, mismatches = 0, n_compared = 0;
   dcc_channel dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_hw_req(src_hw_req), .dst_hw_req(dst_hw_req),
      .src_bus_go(src_bus_go), .src_bus_addr(src_bus_addr), .src_bus_size(src_bus_size), .dst_bus_go(dst_bus_go),
      .dst_bus_addr(dst_bus_addr), .dst_bus_size(dst_bus_size), .bus_prot(bus_prot), .bus_error(bus_error),
      .channel_rank_out(channel_rank_out), .ch_active(ch_active), .int_events(int_events));
   dcc_periph_model per_u (.src_low(src_low), .src_want(src_want), .src_port(src_port), .err_want(err_want),
      .src_hw_req(src_hw_req), .dst_hw_req(dst_hw_req), .bus_error(bus_error));
   initial begin
      forever #10 clk = ~clk;
   end
   // ======================================================================
   // Transfer monitor, cleared by each channel start.
   always @(posedge clk) begin
      if (reg_wr && reg_addr == 12'h060) begin
         ns <= 0;
         nd <= 0;
         ev <= 5'h00;
      end else begin
         if (src_bus_go === 1'b1) begin
            ns <= ns + 1;
            sa <= src_bus_addr;
         end
         if (dst_bus_go === 1'b1) begin
            nd <= nd + 1;
            da <= dst_bus_addr;
         end
         ev <= ev | int_events;
      end
   end
   // ======================================================================
   // Register port and waits
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_act(input logic want, input int lim);
      int i;
      i = 0;
      while (ch_active !== want && i < lim) begin
         @(posedge clk);
         #1 i++;
      end
      `CHK("ch_active", want, ch_active)
      if (ch_active !== want) report_and_stop;
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ======================================================================
   // Scenarios
   task automatic check_regs;
      logic [31:0] v;
      `CHK("prot reset", 4'h3, bus_prot)
      rd(12'h01C, v);
      `CHK("ctl_hi reset", 32'h0000_0002, v)
      rd(12'h040, v);
      `CHK("cfg_lo reset", 32'h0000_0E00, v)
      rd(12'h044, v);
      `CHK("cfg_hi reset", 32'h0000_0004, v)
      rd(12'h200, v);
      `CHK("unmapped", 32'h0000_0000, v)
      wr(12'h044, 32'h0000_001C);
      wr(12'h040, 32'h0000_00E0);
      rd(12'h040, v);
      `CHK("cfg_lo rw", 32'h0000_02E0, v)
      `CHK("prot map", 4'hF, bus_prot)
      `CHK("rank", 3'h7, channel_rank_out)
   endtask
   task automatic run_mem(input logic [31:0] ctl, input logic [11:0] blk, input int es, input int ed,
      input logic [31:0] ea, input logic [31:0] eb, input logic [4:0] eev);
      logic [31:0] v;
      wr(12'h000, 32'h0000_0100);
      wr(12'h008, 32'h0000_0200);
      wr(12'h018, ctl);
      wr(12'h01C, {20'h0_0000, blk});
      wr(12'h060, 32'h0000_0001);
      wait_act(1'b1, 10);
      wait_act(1'b0, 400);
      rd(12'h01C, v);
      `CHK("done", 1'b1, v[12])
      `CHK("src count", es, ns)
      `CHK("dst count", ed, nd)
      `CHK("src last", ea, sa)
      `CHK("dst last", eb, da)
      `CHK("events", eev, ev)
   endtask
   task automatic check_handshake;
      @(posedge clk);
      src_low <= 1'b1;
      src_port <= 4'h3;
      src_want <= 1'b1;
      wr(12'h018, 32'h0020_4000);
      wr(12'h01C, 32'h0000_0004);
      wr(12'h044, 32'h0000_0184);
      wr(12'h040, 32'h0008_0800);
      wr(12'h060, 32'h0000_0001);
      repeat (40) @(posedge clk);
      `CHK("sw ignores hw", 0, ns)
      wr(12'h040, 32'h0008_0000);
      wait_act(1'b0, 200);
      `CHK("hw burst", 4, ns)
      src_want <= 1'b0;
      src_low <= 1'b0;
      wr(12'h044, 32'h0000_0284);
      wr(12'h040, 32'h0000_0000);
      wr(12'h060, 32'h0000_0001);
      repeat (40) @(posedge clk);
      `CHK("idle hw line", 0, ns)
      wr(12'h060, 32'h0000_0000);
   endtask
   task automatic check_pause;
      logic [31:0] v;
      wr(12'h018, 32'h0000_0001);
      wr(12'h01C, 32'h0000_0040);
      wr(12'h040, 32'h0000_0100);
      wr(12'h060, 32'h0000_0001);
      wait_act(1'b1, 10);
      repeat (20) @(posedge clk);
      `CHK("paused src", 0, ns)
      rd(12'h01C, v);
      `CHK("progress", 12'h000, v[11:0])
      rd(12'h040, v);
      `CHK("paused empty", 1'b1, v[9])
      wr(12'h040, 32'h0000_0000);
      repeat (10) @(posedge clk);
      `CHK("resumed", 1'b1, ns > 0)
      err_want <= 1'b1;
      @(posedge clk);
      err_want <= 1'b0;
      wait_act(1'b0, 10);
      `CHK("err event", 1'b1, ev[0])
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      check_regs;
      run_mem(32'h0000_0085, 12'h008, 8, 2, 32'h0000_0107, 32'h0000_01FC, 5'h18);
      run_mem(32'h0000_0D22, 12'h004, 4, 8, 32'h0000_0100, 32'h0000_0200, 5'h00);
      check_handshake;
      check_pause;
      report_and_stop;
   end
endmodule
